//--- rtl/sscbe_pkg.sv
// What this block does
// - shift count from low seven count bits
// - positive count: left shift, zero fill, carry out
// - negative count: right shift, sign fill, carry out
// - zero count: no shift, carry cleared
// - sample sources at start, write at end
// - store sees register value before shift writes
// - memory read happens before memory write
// - negative flag is result sign bit
// - zero flag set when result is zero
// - overflow flag from shift, underflow cleared, latched underflow kept
// - latched overflow set on overflow, else held
// - nonzero count: carry is last bit out
// - saturation mode bit changes nothing here
// - branch only when condition true, else continue
// - register mode loads whole register into counter
// - relative mode uses signed low sixteen bits
// - standard relative target is address plus one
// - delayed relative target is address plus three
// - standard branch takes four cycles, nothing follows
// - delayed branch runs three followers, costs one
// - twenty condition codes checked against flags
package sscbe_pkg;
	localparam int unsigned DATA_W     = 32;                // data and register width
	localparam int unsigned ADDR_W     = 24;                // memory address width
	localparam int unsigned NREG       = 28;                // extended precision registers
	localparam int unsigned RADDR_W    = 5;                 // register port address width
	localparam logic [4:0]  ADDR_STATUS = 5'h1c;            // status word on register port
	localparam logic [4:0]  ADDR_PC     = 5'h1d;            // program counter on register port
	localparam logic [6:0]  OP_SHIFT_STORE = 7'h69;         // bits 31:25 of the parallel pair
	localparam logic [5:0]  OP_BRANCH_COND = 6'h1a;         // bits 31:26 of conditional branch
	localparam int unsigned POS_BR_MODE  = 25;              // 0 register, 1 pc relative
	localparam int unsigned POS_BR_DELAY = 21;              // 0 standard, 1 delayed
	localparam int unsigned POS_COND_LO  = 16;              // condition field, five bits
	localparam int unsigned POS_DST1_LO  = 22;              // shift destination register
	localparam int unsigned POS_COUNT_LO = 19;              // count register
	localparam int unsigned POS_SRC3_LO  = 16;              // store source register
	localparam int unsigned COUNT_W      = 7;               // count bits used
	localparam int unsigned BR_STD_CYCLES = 4;              // standard branch length
	localparam logic [1:0]  BR_DLY_SLOTS  = 2'h3;           // followers of a delayed branch
	localparam logic [DATA_W-1:0] PCREL_STD = 32'h00000001; // standard relative base offset
	localparam logic [DATA_W-1:0] PCREL_DLY = 32'h00000003; // delayed relative base offset
	localparam logic [DATA_W-1:0] PC_RST    = 32'h00000000; // program counter after reset
	localparam logic [7:0]  STATUS_RST  = 8'h00;            // all flags clear after reset

	// status word, carry in bit 0
	typedef struct packed {
		logic overflow_saturation_mode;  // overflow_saturation_mode
		logic latched_underflow_flag;  // latched_underflow_flag
		logic lv;   // latched_overflow_flag
		logic uf;   // underflow_flag
		logic n;
		logic z;
		logic v;
		logic c;
	} sscbe_status_s;

	// memory request, registered
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sscbe_mem_req_s;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,  // ready for the next instruction
		ST_MEM_RD = 3'b001,  // shift operand read on the memory port
		ST_MEM_WT = 3'b010,  // read data back, shift and write registers
		ST_STORE  = 3'b011,  // parallel store on the memory port
		ST_BR_STL = 3'b100   // standard branch dead cycles
	} sscbe_fsm_e;

	typedef struct packed {
		sscbe_fsm_e                  fsm;
		logic [DATA_W-1:0]           pc;
		sscbe_status_s               st;
		logic [NREG-1:0][DATA_W-1:0] rf;
		logic [COUNT_W-1:0]          cnt;
		logic [DATA_W-1:0]           store_val;
		logic [2:0]                  dst1;
		logic [ADDR_W-1:0]           dst2_a;
		logic [1:0]                  stall;
		logic                        br_taken;
		logic [DATA_W-1:0]           br_target;
		logic                        dly_pend;
		logic [1:0]                  dly_left;
		logic [DATA_W-1:0]           dly_target;
		sscbe_mem_req_s              mem;
		logic [DATA_W-1:0]           rdata;
	} sscbe_state_s;
endpackage

//--- rtl/sscbe_exec.sv
`timescale 1ns/10ps
module sscbe_exec
(
	input  wire logic                            clk,
	input  wire logic                            reset,
	input  wire logic                            instr_valid,  // instruction offered
	input  wire logic [sscbe_pkg::DATA_W-1:0]    instr,        // instruction word at fetch_pc
	output logic                                 instr_ready,  // instruction can be taken this cycle
	input  wire logic [sscbe_pkg::ADDR_W-1:0]    src2_addr,    // shift operand address
	input  wire logic [sscbe_pkg::ADDR_W-1:0]    dst2_addr,    // store destination address
	output logic [sscbe_pkg::DATA_W-1:0]         fetch_pc,     // address of offered instruction
	output sscbe_pkg::sscbe_mem_req_s            mem_req,      // memory read or write
	input  wire logic [sscbe_pkg::DATA_W-1:0]    mem_rdata,    // read data, cycle after read
	input  wire logic [sscbe_pkg::RADDR_W-1:0]   reg_addr,     // register port address
	input  wire logic [sscbe_pkg::DATA_W-1:0]    reg_wdata,    // register port write data
	input  wire logic                            reg_wr,       // register port write strobe
	input  wire logic                            reg_rd,       // register port read strobe
	output logic [sscbe_pkg::DATA_W-1:0]         reg_rdata,    // read data, cycle after strobe
	output sscbe_pkg::sscbe_status_s             status        // current status flags
);
	import sscbe_pkg::*;

	sscbe_state_s r;       // registered state
	sscbe_state_s next_r;  // next state

	// evaluate one condition code against the current flags
	function automatic logic cond_true(input logic [4:0] code, input sscbe_status_s s);
		logic t;
		t = 1'b0;
		unique case (code)
			5'h00: t = 1'b1;              // unconditional
			5'h01: t = s.c;               // lower
			5'h02: t = s.c | s.z;         // lower or same
			5'h03: t = ~s.c & ~s.z;       // higher
			5'h04: t = ~s.c;              // higher or same
			5'h05: t = s.z;               // equal
			5'h06: t = ~s.z;              // not equal
			5'h07: t = s.n;               // less than
			5'h08: t = s.n | s.z;         // less or equal
			5'h09: t = ~s.n & ~s.z;       // greater than
			5'h0a: t = ~s.n;              // greater or equal
			5'h0b: t = s.z | s.uf;        // zero or underflow
			5'h0c: t = ~s.v;              // no overflow
			5'h0d: t = s.v;               // overflow
			5'h0e: t = ~s.uf;             // no underflow
			5'h0f: t = s.uf;              // underflow
			5'h10: t = ~s.lv;             // no latched overflow
			5'h11: t = s.lv;              // latched overflow
			5'h12: t = ~s.latched_underflow_flag;            // no latched underflow
			5'h13: t = s.latched_underflow_flag;             // latched underflow
			default: t = 1'b0;            // codes above the twenty never branch
		endcase
		return t;
	endfunction

	// handshake is combinational: only the idle state takes an instruction
	always_comb
	begin
		instr_ready = (r.fsm == ST_IDLE);
	end

	// outputs straight from the state flops
	always_comb
	begin
		fetch_pc  = r.pc;
		mem_req   = r.mem;
		reg_rdata = r.rdata;
		status    = r.st;
	end

	// all next state logic
	always_comb
	begin
		logic                    take;        // instruction accepted
		logic                    is_shift;    // parallel shift and store
		logic                    is_branch;   // conditional branch of either form
		logic                    br_hit;      // branch condition true
		logic [DATA_W-1:0]       disp;        // sign extended displacement
		logic [DATA_W-1:0]       tgt;         // branch destination
		logic [DATA_W-1:0]       seq_pc;      // next sequential address
		logic [DATA_W-1:0]       src;         // shift operand
		logic [COUNT_W-1:0]      mag;         // shift magnitude
		logic [2*DATA_W-1:0]     wide;        // shift working word
		logic [DATA_W-1:0]       res;         // shift result
		logic                    carry;       // last bit out
		logic                    ovf;         // integer overflow on left shift
		logic [4:0]              ridx;        // register mode source index
		take      = 1'b0;
		is_shift  = 1'b0;
		is_branch = 1'b0;
		br_hit    = 1'b0;
		disp      = '0;
		tgt       = '0;
		seq_pc    = '0;
		src       = '0;
		mag       = '0;
		wide      = '0;
		res       = '0;
		carry     = 1'b0;
		ovf       = 1'b0;
		ridx      = '0;
		next_r    = r;

		// register port: writes land first so execution results override them
		if (reg_wr)
		begin
			if (reg_addr < RADDR_W'(NREG))
				next_r.rf[reg_addr] = reg_wdata;
			else if (reg_addr == ADDR_STATUS)
				next_r.st = sscbe_status_s'(reg_wdata[7:0]);
			else if (reg_addr == ADDR_PC)
				next_r.pc = reg_wdata;
		end
		// register port read answer, zero for unmapped addresses
		if (reg_rd)
		begin
			if (reg_addr < RADDR_W'(NREG))
				next_r.rdata = r.rf[reg_addr];
			else if (reg_addr == ADDR_STATUS)
				next_r.rdata = {24'h000000, r.st};
			else if (reg_addr == ADDR_PC)
				next_r.rdata = r.pc;
			else
				next_r.rdata = '0;
		end

		unique case (r.fsm)
			ST_IDLE:
			begin
				take      = instr_valid;
				is_shift  = (instr[31:25] == OP_SHIFT_STORE);
				is_branch = (instr[31:26] == OP_BRANCH_COND) && (instr[24:22] == 3'h0);
				seq_pc    = r.pc + PCREL_STD;
				if (take)
				begin
					// default flow: next sequential word
					next_r.pc = seq_pc;
					// last follower of a delayed branch redirects after it is taken
					if (r.dly_pend)
					begin
						next_r.dly_left = r.dly_left - 2'h1;
						if (r.dly_left == 2'h1)
						begin
							next_r.pc       = r.dly_target;
							next_r.dly_pend = 1'b0;
						end
					end
					if (is_shift)
					begin
						// sources sampled now, destinations written at the end
						next_r.cnt       = r.rf[instr[POS_COUNT_LO +: 3]][COUNT_W-1:0];
						next_r.store_val = r.rf[instr[POS_SRC3_LO +: 3]];
						next_r.dst1      = instr[POS_DST1_LO +: 3];
						next_r.dst2_a    = dst2_addr;
						next_r.mem.rd    = 1'b1;
						next_r.mem.wr    = 1'b0;
						next_r.mem.addr  = src2_addr;
						next_r.fsm       = ST_MEM_RD;
					end
					else if (is_branch && !r.dly_pend)
					begin
						// a branch inside a delay slot is dropped to keep one redirect
						br_hit = cond_true(instr[POS_COND_LO +: 5], r.st);
						disp   = {{16{instr[15]}}, instr[15:0]};
						ridx   = instr[4:0];
						if (!instr[POS_BR_MODE])
							tgt = (ridx < 5'(NREG)) ? r.rf[ridx] : '0;
						else if (instr[POS_BR_DELAY])
							tgt = r.pc + PCREL_DLY + disp;
						else
							tgt = r.pc + PCREL_STD + disp;
						if (instr[POS_BR_DELAY])
						begin
							// one cycle here, redirect after three followers
							if (br_hit)
							begin
								next_r.dly_pend   = 1'b1;
								next_r.dly_left   = BR_DLY_SLOTS;
								next_r.dly_target = tgt;
							end
						end
						else
						begin
							// hold the fetch side off for the remaining cycles
							next_r.pc        = r.pc;
							next_r.br_taken  = br_hit;
							next_r.br_target = tgt;
							next_r.stall     = 2'(BR_STD_CYCLES - 1);
							next_r.fsm       = ST_BR_STL;
						end
					end
				end
			end
			ST_MEM_RD:
			begin
				// the read is on the port this cycle, data comes next cycle
				next_r.mem.rd = 1'b0;
				next_r.fsm    = ST_MEM_WT;
			end
			ST_MEM_WT:
			begin
				src = mem_rdata;
				if (r.cnt == '0)
				begin
					// no shift and carry forced low
					res   = src;
					carry = 1'b0;
				end
				else if (!r.cnt[COUNT_W-1])
				begin
					// left: zeros in at the bottom, carry from the top
					mag   = r.cnt;
					wide  = {{DATA_W{src[DATA_W-1]}}, src} << mag;
					res   = wide[DATA_W-1:0];
					carry = wide[DATA_W];
					ovf   = ~((&wide[2*DATA_W-1:DATA_W-1]) | ~(|wide[2*DATA_W-1:DATA_W-1]));
				end
				else
				begin
					// right: sign copies in at the top, carry from the bottom
					mag   = COUNT_W'(~r.cnt + 7'h01);
					wide  = 64'($signed({src, 32'h00000000}) >>> mag);
					res   = wide[2*DATA_W-1:DATA_W];
					carry = wide[DATA_W-1];
				end
				// saturation mode is never consulted, results stay unclamped
				next_r.rf[r.dst1] = res;
				next_r.st.n  = res[DATA_W-1];
				next_r.st.z  = (res == '0);
				next_r.st.v  = ovf;
				next_r.st.uf = 1'b0;
				next_r.st.lv = r.st.lv | ovf;
				next_r.st.c  = carry;
				// store issued only now, after the operand read returned
				next_r.mem.rd    = 1'b0;
				next_r.mem.wr    = 1'b1;
				next_r.mem.addr  = r.dst2_a;
				next_r.mem.wdata = r.store_val;
				next_r.fsm       = ST_STORE;
			end
			ST_STORE:
			begin
				next_r.mem.wr = 1'b0;
				next_r.fsm    = ST_IDLE;
			end
			ST_BR_STL:
			begin
				// flags untouched through the whole branch
				next_r.stall = r.stall - 2'h1;
				if (r.stall == 2'h1)
				begin
					next_r.pc  = r.br_taken ? r.br_target : r.pc + PCREL_STD;
					next_r.fsm = ST_IDLE;
				end
			end
			default:
			begin
				next_r.fsm = ST_IDLE;
			end
		endcase
	end

	// one register for the whole state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			r            <= '0;
			r.fsm        <= ST_IDLE;
			r.pc         <= PC_RST;
			r.st         <= sscbe_status_s'(STATUS_RST);
		end
		else
		begin
			r <= next_r;
		end
	end
endmodule

//--- verification/sscbe_exec_monitor.sv
`timescale 1ns/10ps
module sscbe_exec_monitor
(
	input wire logic                          clk,
	input wire logic                          reset,
	input wire logic                          instr_valid,
	input wire logic [sscbe_pkg::DATA_W-1:0]  instr,
	input wire logic                          instr_ready,
	input wire logic [sscbe_pkg::ADDR_W-1:0]  src2_addr,
	input wire logic [sscbe_pkg::ADDR_W-1:0]  dst2_addr,
	input wire logic [sscbe_pkg::DATA_W-1:0]  fetch_pc,
	input wire sscbe_pkg::sscbe_mem_req_s     mem_req,
	input wire logic [sscbe_pkg::DATA_W-1:0]  mem_rdata,
	input wire logic [sscbe_pkg::RADDR_W-1:0] reg_addr,
	input wire logic [sscbe_pkg::DATA_W-1:0]  reg_wdata,
	input wire logic                          reg_wr,
	input wire logic                          reg_rd,
	input wire logic [sscbe_pkg::DATA_W-1:0]  reg_rdata,
	input wire sscbe_pkg::sscbe_status_s      status
);
	import sscbe_pkg::*;
	logic is_sh;  // shift with store taken
	logic is_br;  // conditional branch taken
	assign is_sh = instr_valid && instr_ready && instr[31:25] == OP_SHIFT_STORE;
	assign is_br = instr_valid && instr_ready && instr[31:26] == OP_BRANCH_COND;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_read_first: assert property (
		is_sh |=> mem_req.rd && mem_req.addr == $past(src2_addr))
		else $error("operand read missing after take");
	a_store_late: assert property (
		is_sh |-> ##3 mem_req.wr && mem_req.addr == $past(dst2_addr, 3))
		else $error("store not three cycles after take");
	a_std_stall: assert property (
		is_br && !instr[POS_BR_DELAY] |=> !instr_ready [*3] ##1 instr_ready)
		else $error("standard branch not four cycles");
	a_std_pc_hold: assert property (
		is_br && !instr[POS_BR_DELAY] |=> $stable(fetch_pc) [*3])
		else $error("fetch address moved inside standard branch");
	a_delay_slot: assert property (
		is_br && instr[POS_BR_DELAY] |=> instr_ready && fetch_pc == $past(fetch_pc) + 1)
		else $error("delayed branch did not fetch next word");
	a_flags_kept: assert property (is_br |=> $stable(status) [*3])
		else $error("branch changed status");
	a_uf_clear: assert property (
		mem_req.wr |-> !status.uf && status.latched_underflow_flag == $past(status.latched_underflow_flag)
			&& status.overflow_saturation_mode == $past(status.overflow_saturation_mode))
		else $error("underflow flags wrong after shift");
	a_nz_lv: assert property (
		mem_req.wr |-> !(status.n && status.z) && (status.lv || !status.v))
		else $error("shift flags inconsistent");
	a_lv_sticky: assert property (
		status.lv && !(reg_wr && reg_addr == ADDR_STATUS) |=> status.lv)
		else $error("latched overflow lost");
endmodule
bind sscbe_exec sscbe_exec_monitor sscbe_exec_monitor_i
(
	.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
	.instr_ready(instr_ready), .src2_addr(src2_addr), .dst2_addr(dst2_addr),
	.fetch_pc(fetch_pc), .mem_req(mem_req), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.status(status)
);

//--- verification/sscbe_exec_bench.sv
`timescale 1ns/10ps
module sscbe_exec_bench;
	import sscbe_pkg::*;
	logic              clk, reset, instr_valid, reg_wr, reg_rd, instr_ready, dly, mode;
	logic              rd_q = 1'b0;                 // read strobe one cycle back
	logic [31:0]       instr, mem_rdata, reg_wdata, reg_rdata, fetch_pc, v, s, t, pc, tgt;
	logic [23:0]       src2_addr, dst2_addr, a2, d2;
	logic [4:0]        reg_addr;
	logic [2:0]        d1;
	logic [33:0]       r;                           // carry, overflow, result
	sscbe_mem_req_s    mem_req;
	sscbe_status_s     status, st;
	logic [31:0]       mem [logic [23:0]];          // memory behind the port
	logic [63:0]       rq[$], sq[$];                // notes: register reads, stores
	logic [6:0]        cnts[8] = '{7'h10, 7'h68, 7'h00, 7'h20, 7'h60, 7'h01, 7'h7f, 7'h00};
	int                fails, checks_done, seed;
	sscbe_exec sscbe_exec_i (.clk(clk), .reset(reset), .instr_valid(instr_valid),
		.instr(instr), .instr_ready(instr_ready), .src2_addr(src2_addr),
		.dst2_addr(dst2_addr), .fetch_pc(fetch_pc), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status(status));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one port cycle; both strobes set every call so back to back calls never clash
	task automatic port(input logic w, input logic rr, input logic [4:0] a, input logic [31:0] d);
		reg_wr <= w;
		reg_rd <= rr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		rq.push_back({32'h0, e});
		port(1'b0, 1'b1, a, 32'h0);
	endtask
	// hold the word until taken, then wait for the block to go idle again
	task automatic issue(input logic [31:0] w, input logic [23:0] x2, input logic [23:0] y2);
		int n;
		n = 0;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		instr_valid <= 1'b1;
		instr <= w;
		src2_addr <= x2;
		dst2_addr <= y2;
		do @(posedge clk); while (instr_ready !== 1'b1 && ++n < 20);
		instr_valid <= 1'b0;
		do @(posedge clk); while (instr_ready !== 1'b1 && ++n < 40);
	endtask
	// reference shift: sign-extended wide copy keeps every bit that leaves the word
	function automatic logic [33:0] ash(input logic [31:0] x, input logic [6:0] k);
		logic [95:0] w;
		int m;
		m = $signed(k);
		if (m == 0)
			return {2'b00, x};
		if (m > 0)
		begin
			w = {{64{x[31]}}, x} << m;
			return {w[32], w[95:31] != {65{x[31]}}, w[31:0]};
		end
		w = $signed({x, 64'h0}) >>> (-m);
		return {w[63], 1'b0, w[95:64]};
	endfunction
	// condition table, code 0 at the bottom; unused codes never branch
	function automatic logic cond(input logic [4:0] k, input sscbe_status_s f);
		logic [19:0] q;
		q = {f.latched_underflow_flag, ~f.latched_underflow_flag, f.lv, ~f.lv, f.uf, ~f.uf, f.v, ~f.v, f.z | f.uf, ~f.n, ~f.n & ~f.z,
			f.n | f.z, f.n, ~f.z, f.z, ~f.c, ~f.c & ~f.z, f.c | f.z, f.c, 1'b1};
		return k < 5'd20 ? q[k] : 1'b0;
	endfunction
	// result watcher and memory responder; idle read data toggles so stale data shows
	always @(posedge clk)
	begin
		rd_q <= reg_rd;
		if (rd_q)
			check({32'h0, reg_rdata}, rq.pop_front());
		if (mem_req.rd)
			mem_rdata <= mem[mem_req.addr];
		else
			mem_rdata <= ~mem_rdata;
		if (mem_req.wr)
		begin
			check({8'h0, mem_req.addr, mem_req.wdata}, sq.pop_front());
			mem[mem_req.addr] = mem_req.wdata;
		end
	end
	initial
	begin
		#(50 * 5000);
		fails++;
		test_done();
	end
	initial
	begin
		seed = 32'h3c8ce722;
		fails = 0;
		checks_done = 0;
		reset = 1'b1;
		instr_valid = 1'b0;
		instr = 32'h0;
		src2_addr = 24'h0;
		dst2_addr = 24'h0;
		mem_rdata = 32'h0;
		reg_addr = 5'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		// cleared after reset; unmapped place ignores writes
		rd(5'h3, 32'h0);
		rd(ADDR_STATUS, 32'h0);
		rd(ADDR_PC, 32'h0);
		port(1'b1, 1'b0, 5'h1e, $random(seed));
		rd(5'h1e, 32'h0);
		// shift with store; odd passes store the register the shift overwrites
		foreach (cnts[i])
		begin
			d1 = i[0] ? 3'h5 : 3'h0;
			a2 = 24'($random(seed));
			d2 = i[1] ? a2 : 24'($random(seed));   // same place: read before write
			v = $random(seed);
			s = $random(seed);
			t = $random(seed);
			st = t[7:0];
			mem[a2] = s;
			port(1'b1, 1'b0, 5'h1, {s[31:7], cnts[i]});
			port(1'b1, 1'b0, 5'h5, v);
			port(1'b1, 1'b0, ADDR_STATUS, {24'h0, st});
			sq.push_back({8'h0, d2, v});
			r = ash(s, cnts[i]);
			st = {st.overflow_saturation_mode, st.latched_underflow_flag, st.lv | r[32], 1'b0, r[31], r[31:0] == 32'h0, r[32], r[33]};
			issue({OP_SHIFT_STORE, d1, 3'h1, 3'h5, t[31:16]}, a2, d2);
			rd({2'h0, d1}, r[31:0]);
			rd(ADDR_STATUS, {24'h0, st});
		end
		// every condition code, both address modes, both forms
		for (int k = 0; k < 22; k++)
		begin
			v = $random(seed);
			s = $random(seed);
			t = $random(seed);
			st = v[7:0];
			pc = {8'h0, v[31:8]};
			dly = (k % 3 == 0);
			mode = k[0];
			port(1'b1, 1'b0, ADDR_STATUS, {24'h0, st});
			port(1'b1, 1'b0, ADDR_PC, pc);
			port(1'b1, 1'b0, 5'h2, t);
			tgt = mode ? pc + (dly ? 32'h3 : 32'h1) + {{16{s[15]}}, s[15:0]} : t;
			if (!cond(k[4:0], st))
				tgt = pc + (dly ? 32'h4 : 32'h1);
			issue({OP_BRANCH_COND, mode, 3'h0, dly, k[4:0], mode ? s[15:0] : 16'h0002},
				a2, d2);
			if (dly)
			begin
				rd(ADDR_PC, pc + 32'h1);
				repeat (3) issue(32'h0, a2, d2);
			end
			rd(ADDR_PC, tgt);
			rd(ADDR_STATUS, {24'h0, st});
		end
		port(1'b0, 1'b0, 5'h0, 32'h0);
		repeat (3) @(posedge clk);
		test_done();
	end
endmodule
